// ---- verilog/adc_frontend_defs.svh ----
// offsets, control-byte fields, reset values and timing counts
`ifndef ADC_FRONTEND_DEFS_SVH
`define ADC_FRONTEND_DEFS_SVH

// core clock and internal conversion time (typical)
`define CORE_CLK_MHZ       125
`define INT_CONV_NS        25000
`define INT_CONV_CYCLES    ((`INT_CONV_NS * `CORE_CLK_MHZ) / 1000)

// register byte offsets
`define REG_CONTROL        4'h0
`define REG_SAMPLE         4'h4
`define REG_STATUS         4'h8
`define REG_CONV_COUNT     4'hC

// control register field
`define CTRLREG_FOUR_INPUT 0

// control byte field positions
`define CB_START           7
`define CB_PICK_2          6
`define CB_PICK_1          5
`define CB_PICK_0          4
`define CB_POLARITY        3
`define CB_INPUT_CFG       2
`define CB_POWER_KEEP      1
`define CB_CLOCK_SOURCE    0

// reset values and bipolar code flip
`define CTRL_BYTE_RESET    8'h00
`define STROBE_RESET       1'b1
`define SAMPLE_RESET       8'h00
`define BIPOLAR_FLIP       8'h80

// per-falling-edge counts of the output sequencer
`define STROBE_LAST        3'h1
`define SHIFT_LAST         3'h6
`define READY_MSB_FALL     3'h1

// bus responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ---- verilog/adc_frontend_pkg.sv ----
// types shared by the serial front end
package adc_frontend_pkg;

   typedef enum logic [2:0]
   {
      OUT_IDLE,
      OUT_STROBE,
      OUT_SHIFT,
      INT_CONV,
      INT_READY
   } out_state_e;

   typedef logic [7:0] byte_t;
   typedef logic [2:0] chan_t;

endpackage

// ---- verilog/channel_route.sv ----
// control-byte channel pick to mux routing
`timescale 1ns/100ps
module channel_route
   import adc_frontend_pkg::*;
(
   // pick fields and modes
   input  wire logic [2:0] pick,
   input  wire logic       single_ended,
   input  wire logic       four_input,
   // routing
   output chan_t           pos_ch,
   output chan_t           neg_ch,
   output logic            neg_is_return
);

   // pick_0 drops out on the four-input part
   function automatic chan_t route_index(input logic [2:0] p,
                                         input logic four);
      route_index = four ? {1'b0, p[1], p[2]} : {p[1], p[0], p[2]};
   endfunction

   always_comb
   begin
      pos_ch        = route_index(pick, four_input);
      neg_is_return = single_ended;
      // even/odd partner of the positive input in a pair
      neg_ch        = single_ended ? 3'h0 : (pos_ch ^ 3'h1);
   end

endmodule // channel_route

// ---- verilog/adc_serial_control_frontend.sv ----
// serial control front end of the 8-bit converter with AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "adc_frontend_defs.svh"
module adc_serial_control_frontend
   import adc_frontend_pkg::*;
#(
   parameter int ADDR_W          = 4,
   parameter int INT_CONV_CYCLES = `INT_CONV_CYCLES
)
(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst,
   // serial pins
   input  wire logic              cs_n,
   input  wire logic              sclk,
   input  wire logic              din,
   output logic                   dout,
   output logic                   dout_oe_n,
   output logic                   conversion_strobe,
   output logic                   strobe_oe_n,
   // decoded conversion setup
   output chan_t                  pos_ch,
   output chan_t                  neg_ch,
   output logic                   neg_is_return,
   output logic                   polarity_mode,
   output logic                   input_config,
   output logic                   power_keep,
   output logic                   clock_source,
   output logic                   conversion_start,
   // AXI4-Lite write
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready
);

   logic          cs_m, cs_s, cs_d;
   logic          sclk_m, sclk_s, sclk_d;
   logic          din_m, din_s;
   logic          sclk_rise, sclk_fall, cs_rise;
   logic          rx_active, byte_pending, hunt_ok;
   logic [2:0]    rx_cnt;
   logic [6:0]    rx_sr;
   byte_t         ctrl, sample, result, out_sr, conv_count;
   logic [2:0]    out_cnt;
   logic [11:0]   conv_timer;
   logic          int_done, start_now, four_input;
   out_state_e    state;
   chan_t         route_pos, route_neg;
   logic          route_ret;
   logic          aw_held, w_held;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0]   w_data_q;
   logic [3:0]    w_strb_q;

   function automatic byte_t conv_code(input byte_t s, input logic uni);
      conv_code = uni ? s : (s ^ `BIPOLAR_FLIP);
   endfunction

   function automatic logic reg_known(input logic [ADDR_W-1:0] a);
      reg_known = (a == `REG_CONTROL) || (a == `REG_SAMPLE) ||
                  (a == `REG_STATUS)  || (a == `REG_CONV_COUNT);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge finding; edges compare the second and third stages
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cs_m   <= 1'b1;
         cs_s   <= 1'b1;
         cs_d   <= 1'b1;
         sclk_m <= 1'b0;
         sclk_s <= 1'b0;
         sclk_d <= 1'b0;
         din_m  <= 1'b0;
         din_s  <= 1'b0;
      end
      else
      begin
         cs_m   <= cs_n;
         cs_s   <= cs_m;
         cs_d   <= cs_s;
         sclk_m <= sclk;
         sclk_s <= sclk_m;
         sclk_d <= sclk_s;
         din_m  <= din;
         din_s  <= din_m;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;
   assign cs_rise   = cs_s & ~cs_d;
   // no new start bit until an external-mode result MSB has gone out
   assign hunt_ok   = !byte_pending && (state != OUT_STROBE);
   assign start_now = sclk_fall && !cs_s && byte_pending;
   assign int_done  = (state == INT_CONV) && (conv_timer == 12'h000);

   ////////////////////////////////////////////////////////////////////////
   // control byte receiver
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_active    <= 1'b0;
         rx_cnt       <= 3'h0;
         rx_sr        <= 7'h00;
         byte_pending <= 1'b0;
         ctrl         <= `CTRL_BYTE_RESET;
      end
      else if (cs_s)
      begin
         // deselect abandons a partial byte
         rx_active    <= 1'b0;
         rx_cnt       <= 3'h0;
         byte_pending <= 1'b0;
      end
      else
      begin
         if (start_now)
            byte_pending <= 1'b0;
         if (sclk_rise)
         begin
            if (rx_active)
            begin
               rx_sr  <= {rx_sr[5:0], din_s};
               rx_cnt <= 3'(rx_cnt + 3'h1);
               if (rx_cnt == 3'h7)
               begin
                  ctrl         <= {rx_sr, din_s};
                  byte_pending <= 1'b1;
                  rx_active    <= 1'b0;
               end
            end
            else if (din_s && hunt_ok)
            begin
               rx_active <= 1'b1;
               rx_sr     <= 7'h01;
               rx_cnt    <= 3'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // internal-clock conversion timer
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         conv_timer <= 12'h000;
      else if (start_now)
         conv_timer <= 12'(INT_CONV_CYCLES - 1);
      else if ((state == INT_CONV) && (conv_timer != 12'h000))
         conv_timer <= 12'(conv_timer - 12'h001);
   end

   ////////////////////////////////////////////////////////////////////////
   // output sequencer: strobe and serial data
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state             <= OUT_IDLE;
         conversion_strobe <= `STROBE_RESET;
         dout              <= 1'b0;
         out_sr            <= 8'h00;
         out_cnt           <= 3'h0;
         result            <= 8'h00;
         conv_count        <= 8'h00;
         conversion_start  <= 1'b0;
      end
      else
      begin
         conversion_start <= 1'b0;
         if (start_now)
         begin
            result            <= conv_code(sample, ctrl[`CB_POLARITY]);
            conversion_start  <= 1'b1;
            conv_count        <= 8'(conv_count + 8'h01);
            out_cnt           <= 3'h0;
            dout              <= 1'b0;
            conversion_strobe <= ctrl[`CB_CLOCK_SOURCE];
            state <= ctrl[`CB_CLOCK_SOURCE] ? OUT_STROBE : INT_CONV;
         end
         else if (cs_rise && ((state == OUT_STROBE) || (state == OUT_SHIFT)))
         begin
            // deselect ends an external-mode conversion
            state             <= OUT_IDLE;
            dout              <= 1'b0;
            conversion_strobe <= 1'b0;
         end
         else if (int_done)
         begin
            // internal mode: strobe not tied to the shift clock
            state             <= INT_READY;
            conversion_strobe <= 1'b1;
            out_cnt           <= 3'h0;
         end
         else if (sclk_fall && !cs_s)
         begin
            case (state)
               OUT_STROBE:
                  if (out_cnt == `STROBE_LAST)
                  begin
                     conversion_strobe <= 1'b0;
                     dout   <= result[7];
                     out_sr <= {result[6:0], 1'b0};
                     out_cnt <= 3'h0;
                     state  <= OUT_SHIFT;
                  end
                  else
                     out_cnt <= 3'(out_cnt + 3'h1);
               OUT_SHIFT:
               begin
                  dout    <= out_sr[7];
                  out_sr  <= {out_sr[6:0], 1'b0};
                  out_cnt <= 3'(out_cnt + 3'h1);
                  if (out_cnt == `SHIFT_LAST)
                     state <= OUT_IDLE;
               end
               INT_READY:
                  if (out_cnt == `READY_MSB_FALL)
                  begin
                     dout    <= result[7];
                     out_sr  <= {result[6:0], 1'b0};
                     out_cnt <= 3'h0;
                     state   <= OUT_SHIFT;
                  end
                  else
                     out_cnt <= 3'(out_cnt + 3'h1);
               OUT_IDLE,
               INT_CONV:
                  dout <= 1'b0;
               default:
                  state <= OUT_IDLE;
            endcase
         end
      end
   end

   // pins float while deselected; internal-mode strobe always drives
   assign dout_oe_n   = cs_s;
   assign strobe_oe_n = cs_s & ctrl[`CB_CLOCK_SOURCE];

   ////////////////////////////////////////////////////////////////////////
   // channel routing and registered setup outputs
   channel_route u_route
   (
      .pick          (ctrl[`CB_PICK_2:`CB_PICK_0]),
      .single_ended  (ctrl[`CB_INPUT_CFG]),
      .four_input    (four_input),
      .pos_ch        (route_pos),
      .neg_ch        (route_neg),
      .neg_is_return (route_ret)
   );

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         pos_ch        <= 3'h0;
         neg_ch        <= 3'h0;
         neg_is_return <= 1'b0;
         polarity_mode <= 1'b0;
         input_config  <= 1'b0;
         power_keep    <= 1'b0;
         clock_source  <= 1'b0;
      end
      else
      begin
         pos_ch        <= route_pos;
         neg_ch        <= route_neg;
         neg_is_return <= route_ret;
         polarity_mode <= ctrl[`CB_POLARITY];
         input_config  <= ctrl[`CB_INPUT_CFG];
         power_keep    <= ctrl[`CB_POWER_KEEP];
         clock_source  <= ctrl[`CB_CLOCK_SOURCE];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   assign awready = !aw_held;
   assign wready  = !w_held;
   assign arready = !rvalid;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         aw_held    <= 1'b0;
         w_held     <= 1'b0;
         aw_addr_q  <= '0;
         w_data_q   <= 32'h0000_0000;
         w_strb_q   <= 4'h0;
         bvalid     <= 1'b0;
         bresp      <= `RESP_OKAY;
         four_input <= 1'b0;
         sample     <= `SAMPLE_RESET;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_held   <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_held   <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (bvalid && bready)
            bvalid <= 1'b0;
         else if (aw_held && w_held && !bvalid)
         begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= reg_known(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
            if (w_strb_q[0] && (aw_addr_q == `REG_CONTROL))
               four_input <= w_data_q[`CTRLREG_FOUR_INPUT];
            if (w_strb_q[0] && (aw_addr_q == `REG_SAMPLE))
               sample <= w_data_q[7:0];
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `RESP_OKAY;
      end
      else if (rvalid && rready)
         rvalid <= 1'b0;
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rresp  <= reg_known(araddr) ? `RESP_OKAY : `RESP_SLVERR;
         case (araddr)
            `REG_CONTROL:    rdata <= {31'h0000_0000, four_input};
            `REG_SAMPLE:     rdata <= {24'h00_0000, sample};
            `REG_STATUS:     rdata <= {15'h0000, conversion_strobe,
                                       (state != OUT_IDLE), route_ret,
                                       route_neg, route_pos, ctrl};
            `REG_CONV_COUNT: rdata <= {24'h00_0000, conv_count};
            default:         rdata <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_shift_in;
      sclk_rise && !cs_s && rx_active |=> rx_sr[0] == $past(din_s);
   endproperty
   a_shift_in: assert property (p_shift_in)
      else $error("input bit not shifted in");

   property p_zero_ignored;
      sclk_rise && !cs_s && !rx_active && !din_s && !byte_pending
         |=> !rx_active && !byte_pending;
   endproperty
   a_zero_ignored: assert property (p_zero_ignored)
      else $error("leading zero started a byte");

   property p_start_msb;
      $rose(byte_pending) |-> ctrl[`CB_START];
   endproperty
   a_start_msb: assert property (p_start_msb)
      else $error("control byte msb is not the start bit");

   property p_route_eight;
      !four_input |-> route_pos == {ctrl[5], ctrl[4], ctrl[6]} &&
         (ctrl[2] || route_neg == {ctrl[5], ctrl[4], ~ctrl[6]});
   endproperty
   a_route_eight: assert property (p_route_eight)
      else $error("eight-input routing wrong");

   property p_route_four;
      four_input |-> route_pos == {1'b0, ctrl[5], ctrl[6]} &&
         (ctrl[2] ? route_ret : route_neg == {1'b0, ctrl[5], ~ctrl[6]});
   endproperty
   a_route_four: assert property (p_route_four)
      else $error("four-input routing wrong");

   property p_polarity;
      start_now |=> conversion_start &&
         result == conv_code($past(sample), $past(ctrl[`CB_POLARITY]));
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("result coding or start wrong");

   property p_strobe_msb;
      state == OUT_STROBE && out_cnt == `STROBE_LAST && sclk_fall &&
         !cs_s && !byte_pending
         |=> state == OUT_SHIFT && !conversion_strobe && dout == result[7];
   endproperty
   a_strobe_msb: assert property (p_strobe_msb)
      else $error("strobe did not end with msb");

   property p_strobe_two;
      start_now && ctrl[`CB_CLOCK_SOURCE] |=> conversion_strobe && !dout;
   endproperty
   a_strobe_two: assert property (p_strobe_two)
      else $error("strobe not raised at conversion start");

   property p_fall_only;
      ctrl[`CB_CLOCK_SOURCE] && state != INT_CONV && !sclk_fall && !cs_rise
         |=> $stable(dout) && $stable(conversion_strobe);
   endproperty
   a_fall_only: assert property (p_fall_only)
      else $error("output moved off a falling edge");

   property p_ten_clocks;
      state == OUT_SHIFT && out_cnt == `SHIFT_LAST && sclk_fall && !cs_s &&
         !byte_pending |=> state == OUT_IDLE && dout == $past(out_sr[7]);
   endproperty
   a_ten_clocks: assert property (p_ten_clocks)
      else $error("result length wrong");

   property p_zeros_after;
      state == OUT_IDLE && sclk_fall && !cs_s && !byte_pending |=> !dout;
   endproperty
   a_zeros_after: assert property (p_zeros_after)
      else $error("nonzero after result");

   c_ext_done:     cover property (state == OUT_SHIFT ##1 state == OUT_IDLE);
   c_back_to_back: cover property (state == OUT_SHIFT ##1 state == OUT_IDLE
                                   ##[1:20] start_now);
   c_int_ready:    cover property (int_done);
   c_bus_write:    cover property (bvalid && bready && bresp == `RESP_OKAY);

endmodule // adc_serial_control_frontend

// ---- test/host_spi_model.sv ----
// host serial master model: mode 0 frames of up to 32 bits
`timescale 1ns/100ps
module host_spi_model
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // frame request and capture
   input  wire logic        go,
   input  wire logic [31:0] tx,
   input  wire logic [5:0]  nbits,
   output logic             done,
   output logic [31:0]      rx,
   output logic [31:0]      sb,
   // serial pins
   output logic             cs_n,
   output logic             sclk,
   output logic             din,
   input  wire logic        dout,
   input  wire logic        strobe
);
   logic        busy;
   logic [3:0]  ph;
   logic [5:0]  cnt;
   logic [31:0] sh;

   /////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         {busy, done, cs_n, sclk, din} <= 5'b00100;
         {ph, cnt, sh, rx, sb} <= '0;
      end
      else if (!busy)
      begin
         done <= 1'b0;
         din  <= ~din; // idle line must never look stable
         if (go)
         begin
            busy <= 1'b1;
            cs_n <= 1'b0;
            ph   <= 4'h0;
            cnt  <= 6'h0;
            din  <= tx[nbits-6'h1];
            sh   <= tx << (6'd33 - nbits);
         end
      end
      else
      begin
         // ten core cycles a bit; rate scaled down to keep runs short
         ph <= ph + 4'h1;
         if ((ph == 4'h4) && (cnt == nbits))
         begin
            // select rises half a bit after the last falling edge
            busy <= 1'b0;
            cs_n <= 1'b1;
            done <= 1'b1;
         end
         else if (ph == 4'h4)
         begin
            sclk <= 1'b1;
            rx   <= {rx[30:0], dout};
            sb   <= {sb[30:0], strobe};
         end
         if (ph == 4'h9)
         begin
            sclk <= 1'b0;
            ph   <= 4'h0;
            cnt  <= cnt + 6'h1;
            din  <= sh[31];
            sh   <= sh << 1;
         end
      end
   end
endmodule // host_spi_model

// ---- test/tb_adc_serial_control_frontend.sv ----
// self-checking bench of the serial control front end
`timescale 1ns/100ps
`include "adc_frontend_defs.svh"
module tb_adc_serial_control_frontend;
   logic        core_clk, rst, go, done, cs_n, sclk, din, dout, strobe;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, doe, soe;
   logic        arvalid, arready, rvalid, rready, nir, pm, ic, pk, cs;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, tx, rx, sb, d, seed;
   logic [1:0]  bresp, rresp, r;
   logic [2:0]  pos, neg;
   logic [5:0]  nb;
   logic [7:0]  cb, smp, res, c0;
   int          bad_count, n_tests, i;

   adc_serial_control_frontend #(.INT_CONV_CYCLES(20)) i_dut
   (
      .core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din),
      .dout(dout), .dout_oe_n(doe), .conversion_strobe(strobe),
      .strobe_oe_n(soe), .pos_ch(pos), .neg_ch(neg), .neg_is_return(nir),
      .polarity_mode(pm), .input_config(ic), .power_keep(pk),
      .clock_source(cs), .conversion_start(), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready)
   );
   host_spi_model i_host
   (
      .core_clk(core_clk), .rst(rst), .go(go), .tx(tx), .nbits(nb),
      .done(done), .rx(rx), .sb(sb), .cs_n(cs_n), .sclk(sclk), .din(din),
      .dout(dout), .strobe(strobe)
   );

   /////////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction

   // {neg is return, negative, positive}
   function automatic logic [6:0] route(input logic [2:0] p, input logic s, f);
      logic [2:0] q;
      q = f ? {1'b0, p[1], p[2]} : {p[1], p[0], p[2]};
      return {s, s ? 3'h0 : q ^ 3'h1, q};
   endfunction

   task automatic chk(input logic [31:0] g, e);
      n_tests++;
      if (g !== e)
      begin
         $display("[ERR] %0t got %h exp %h", $time, g, e);
         bad_count++;
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic hang();
      bad_count++;
      finish_test();
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge core_clk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
      for (int n = 0; n < 50; n++)
      begin
         @(posedge core_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid)
         begin
            bready <= 1'b0;
            r = bresp;
            return;
         end
      end
      hang();
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      for (int n = 0; n < 50; n++)
      begin
         @(posedge core_clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid)
         begin
            rready <= 1'b0;
            {r, d} = {rresp, rdata};
            return;
         end
      end
      hang();
   endtask

   // cs_n left high some cycles so the synchroniser sees the gap
   task automatic frame(input logic [31:0] t, input logic [5:0] b);
      @(posedge core_clk);
      {tx, nb, go} <= {t, b, 1'b1};
      @(posedge core_clk);
      go <= 1'b0;
      for (int n = 0; n < 1000; n++)
      begin
         @(posedge core_clk);
         if (done)
         begin
            repeat (8) @(posedge core_clk);
            return;
         end
      end
      hang();
   endtask

   initial
   begin
      rst = 1'b1;
      {go, tx, nb, awaddr, wdata, awvalid, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
      wstrb = 4'hF;
      {seed, bad_count, n_tests} = {32'h8177, 64'h0};
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (8) @(posedge core_clk);
      rd(`REG_CONTROL);
      chk(d, 32'h0);
      wr(4'h1, 32'h1);
      chk(r, `RESP_SLVERR);
      rd(4'h1);
      chk(r, `RESP_SLVERR);
      $display("register checks done");
      for (i = 0; i < 32; i++)
      begin
         seed = xs(seed);
         smp = seed[7:0];
         cb = {1'b1, i[2:0], seed[8], i[3], seed[9], 1'b1};
         res = cb[3] ? smp : smp ^ 8'h80;
         wr(`REG_CONTROL, {31'h0, i[4]});
         wr(`REG_SAMPLE, {24'h0, smp});
         frame({8'h0, cb, 16'h0}, 6'd24 + seed[11:10]);
         chk(rx[15:0], {2'b00, res, 6'h00});
         chk(sb[15:13], 3'b110);
         chk({nir, neg, pos}, route(cb[6:4], cb[2], i[4]));
         chk({pm, ic, pk, cs}, cb[3:0]);
         chk({doe, soe}, 2'b11);
         rd(`REG_STATUS);
         chk(d[7:0], cb);
      end
      $display("decode and 24-clock reads done");
      seed = xs(seed);
      smp = seed[7:0];
      wr(`REG_CONTROL, 32'h0);
      wr(`REG_SAMPLE, {24'h0, smp});
      rd(`REG_CONV_COUNT);
      c0 = d[7:0];
      frame(32'hFFFF_FFFF, 6'd30);
      chk(rx[19:0], {smp, 2'b00, smp, 2'b00});
      rd(`REG_CONV_COUNT);
      c0 = d[7:0] - c0;
      chk(c0, 8'h03);
      frame(32'h0000_008E, 6'd8);
      chk(strobe, 1'b0);
      for (i = 0; i < 60 && strobe !== 1'b1; i++)
         @(posedge core_clk);
      chk(strobe, 1'b1);
      frame(32'h0, 6'd10);
      chk(rx[7:0], smp);
      chk({doe, soe}, 2'b10);
      $display("back-to-back and internal clock done");
      finish_test();
   end
endmodule // tb_adc_serial_control_frontend
